/* core/cgl_pkg.sv */
// Shared constants and types of the clock generator low-power and break logic.
// Assumes a single 40 MHz aclk domain and an AXI4-Lite register port.
package cgl_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 25;

  // Register byte offsets
  localparam logic [7:0] OFS_LOOP_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_BREAK_CTRL = 8'h10;

  // Field positions, loop_control_reg
  localparam int POS_LOOP_POWER = 0;
  localparam int POS_BASE_SELECT = 1;
  localparam int POS_AUTO_BW = 2;
  // Field positions, status and mask
  localparam int POS_LOCK_FLAG = 0;
  localparam int POS_LOCK_IND = 1;
  localparam int POS_ACTIVE_SRC = 2;
  localparam int POS_MODE_LO = 4;
  // Field positions, config and break control
  localparam int POS_OSC_RUN_STOP = 0;
  localparam int POS_BREAK_CLEAR = 0;

  // Reset values
  localparam logic RST_LOOP_POWER = 1'b0;
  localparam logic RST_BASE_SELECT = 1'b0;
  localparam logic RST_AUTO_BW = 1'b0;
  localparam logic RST_IRQ_MASK = 1'b0;
  localparam logic RST_OSC_RUN_STOP = 1'b0;
  localparam logic RST_BREAK_CLEAR = 1'b0;

  // Timing: acquisition time of the loop model, rounded up to cycles
  localparam int LOCK_ACQ_TIME_NS = 100000;
  localparam int LOCK_ACQ_CYCLES = (LOCK_ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Half periods of the modelled oscillator and loop outputs, in aclk cycles
  localparam int XTAL_HALF_CYCLES = 4;
  localparam int LOOP_HALF_CYCLES = 2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } cgl_mode_type;

  typedef struct packed {
    logic auto_bw;
    logic base_clock_select;
    logic loop_power_enable;
  } cgl_ctrl_type;

endpackage : cgl_pkg

/* core/cgl_clk_divider.sv */
// Gated clock divider producing a square wave from aclk.
// Assumes run comes from aclk-domain logic; output is a flop.
`timescale 1ns/10ps
`default_nettype none

module cgl_clk_divider #(
  parameter int HALF = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and output
  input wire logic run,
  output logic clk_out
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic out_reg;
  logic out_next;
  localparam logic [7:0] LAST = 8'(HALF - 1);

  // A high phase always completes, and a restart begins with a full low phase,
  // so neither stopping nor starting makes a runt pulse
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (out_reg || run) begin
      if (cnt_reg == LAST) begin
        cnt_next = 8'h00;
        out_next = ~out_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else begin
      cnt_next = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

endmodule : cgl_clk_divider

`default_nettype wire

/* core/cgl_clock_gen.sv */
// Clock generator low-power, stop and break behaviour with AXI4-Lite registers.
// Assumes CPU mode strobes and break_active come from aclk-domain logic;
// lock_disturb is an asynchronous pin.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cgl_clock_gen
  import cgl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // CPU and system integration
  input wire logic wait_enter,
  input wire logic stop_enter,
  input wire logic mode_exit,
  input wire logic break_active,
  // Loop disturbance pin
  input wire logic lock_disturb,
  // Clock generator outputs
  output logic crystal_clock_out,
  output logic base_clock_out,
  output logic clock_gen_irq
);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_LOOP_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_MASK) ||
                (a == OFS_CONFIG) || (a == OFS_BREAK_CTRL);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state

  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wlane_reg, wlane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;

  // Register state
  cgl_ctrl_type ctrl_reg, ctrl_next;
  logic mask_reg, mask_next;
  logic osc_run_in_stop_reg, osc_run_in_stop_next;
  logic break_clear_enable_reg, break_clear_enable_next;
  logic lock_change_flag_reg, lock_change_flag_next;

  // Mode and loop model state
  cgl_mode_type mode_reg, mode_next;
  logic [15:0] acq_cnt_reg, acq_cnt_next;
  logic locked_reg, locked_next;
  logic lock_ind_prev_reg, lock_ind_prev_next;
  logic dist_meta_reg, dist_sync_reg;

  // Base clock switch state
  logic src_sel_reg, src_sel_next;
  logic gate_reg, gate_next;
  logic base_reg, base_next;
  logic irq_reg, irq_next;

  logic osc_run, loop_run, xtal_clk, loop_clk, lock_ind, lock_event;
  logic src_clk, in_stop;

  localparam logic [15:0] ACQ_LAST = 16'(LOCK_ACQ_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake

  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    // Address and data are taken in either order; response once both are in
    if (awvalid && awready) begin
      aw_held_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_held_next = 1'b1;
      wdata_next = wdata;
      wlane_next = wstrb[0];
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      // Reads have no side effect, so break-time reads never touch the flag
      case (araddr)
        OFS_LOOP_CTRL: begin
          rdata_next[POS_LOOP_POWER] = ctrl_reg.loop_power_enable;
          rdata_next[POS_BASE_SELECT] = ctrl_reg.base_clock_select;
          rdata_next[POS_AUTO_BW] = ctrl_reg.auto_bw;
        end
        OFS_STATUS: begin
          rdata_next[POS_LOCK_FLAG] = lock_change_flag_reg;
          rdata_next[POS_LOCK_IND] = lock_ind;
          rdata_next[POS_ACTIVE_SRC] = src_sel_reg;
          rdata_next[POS_MODE_LO +: 2] = mode_reg;
        end
        OFS_IRQ_MASK: rdata_next[POS_LOCK_FLAG] = mask_reg;
        OFS_CONFIG: rdata_next[POS_OSC_RUN_STOP] = osc_run_in_stop_reg;
        OFS_BREAK_CTRL: rdata_next[POS_BREAK_CLEAR] = break_clear_enable_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and lock-change flag

  always_comb begin
    logic wr_lane;
    wr_lane = wr_fire && wlane_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    osc_run_in_stop_next = osc_run_in_stop_reg;
    break_clear_enable_next = break_clear_enable_reg;
    lock_change_flag_next = lock_change_flag_reg;
    if (wr_lane) begin
      case (waddr_reg)
        OFS_LOOP_CTRL: begin
          // Software powers the loop down itself; of the mode changes only entering stop halts it
          ctrl_next.loop_power_enable = wdata_reg[POS_LOOP_POWER];
          ctrl_next.base_clock_select = wdata_reg[POS_BASE_SELECT];
          ctrl_next.auto_bw = wdata_reg[POS_AUTO_BW];
        end
        OFS_STATUS: begin
          // Break-time clears only when allowed, and then they stick
          if (wdata_reg[POS_LOCK_FLAG] && (!break_active || break_clear_enable_reg)) begin
            lock_change_flag_next = 1'b0;
          end
        end
        OFS_IRQ_MASK: mask_next = wdata_reg[POS_LOCK_FLAG];
        OFS_CONFIG: osc_run_in_stop_next = wdata_reg[POS_OSC_RUN_STOP];
        OFS_BREAK_CTRL: break_clear_enable_next = wdata_reg[POS_BREAK_CLEAR];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    // A lock change in the same cycle as a clear wins
    if (lock_event) begin
      lock_change_flag_next = 1'b1;
    end
    // Manual bandwidth mode keeps the flag at zero
    if (!ctrl_reg.auto_bw) begin
      lock_change_flag_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '{auto_bw: RST_AUTO_BW, base_clock_select: RST_BASE_SELECT,
                    loop_power_enable: RST_LOOP_POWER};
      mask_reg <= RST_IRQ_MASK;
      osc_run_in_stop_reg <= RST_OSC_RUN_STOP;
      break_clear_enable_reg <= RST_BREAK_CLEAR;
      lock_change_flag_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      osc_run_in_stop_reg <= osc_run_in_stop_next;
      break_clear_enable_reg <= break_clear_enable_next;
      lock_change_flag_reg <= lock_change_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode and loop lock model

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dist_meta_reg <= 1'b0;
      dist_sync_reg <= 1'b0;
    end else begin
      dist_meta_reg <= lock_disturb;
      dist_sync_reg <= dist_meta_reg;
    end
  end

  assign in_stop = (mode_reg == MODE_STOP);
  // Wait mode changes nothing here
  assign osc_run = !in_stop || osc_run_in_stop_reg;
  // Loop keeps running while powered, selected or not, also in wait
  assign loop_run = ctrl_reg.loop_power_enable && !in_stop;
  assign lock_ind = ctrl_reg.auto_bw && locked_reg;
  assign lock_event = ctrl_reg.auto_bw && (lock_ind != lock_ind_prev_reg);

  always_comb begin
    mode_next = mode_reg;
    acq_cnt_next = acq_cnt_reg;
    locked_next = locked_reg;
    lock_ind_prev_next = lock_ind;
    case (mode_reg)
      MODE_RUN: begin
        if (stop_enter) begin
          mode_next = MODE_STOP;
        end else if (wait_enter) begin
          mode_next = MODE_WAIT;
        end
      end
      MODE_WAIT, MODE_STOP: begin
        if (mode_exit) begin
          mode_next = MODE_RUN;
        end
      end
      default: mode_next = MODE_RUN;
    endcase
    // Acquisition and loss of lock go on in wait as in run
    if (!loop_run || dist_sync_reg) begin
      acq_cnt_next = 16'h0000;
      locked_next = 1'b0;
    end else if (!locked_reg) begin
      if (acq_cnt_reg == ACQ_LAST) begin
        locked_next = 1'b1;
      end else begin
        acq_cnt_next = acq_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RUN;
      acq_cnt_reg <= 16'h0000;
      locked_reg <= 1'b0;
      lock_ind_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      acq_cnt_reg <= acq_cnt_next;
      locked_reg <= locked_next;
      lock_ind_prev_reg <= lock_ind_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources and glitch-free base clock selection

  cgl_clk_divider #(.HALF(XTAL_HALF_CYCLES)) u_xtal (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(osc_run),
    .clk_out(xtal_clk)
  );

  cgl_clk_divider #(.HALF(LOOP_HALF_CYCLES)) u_loop (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(loop_run),
    .clk_out(loop_clk)
  );

  assign src_clk = src_sel_reg ? loop_clk : xtal_clk;

  always_comb begin
    src_sel_next = src_sel_reg;
    gate_next = gate_reg;
    // Swap only while both sources are low so no sliver reaches the output
    if (!xtal_clk && !loop_clk) begin
      src_sel_next = ctrl_reg.base_clock_select;
    end
    // The gate moves only while the selected source is low
    if (!src_clk) begin
      gate_next = !in_stop;
    end
    base_next = gate_reg && src_clk;
    // Flag and mask are held, but the output stays low with the oscillator off
    irq_next = lock_change_flag_reg && mask_reg && osc_run;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel_reg <= 1'b0;
      gate_reg <= 1'b0;
      base_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      src_sel_reg <= src_sel_next;
      gate_reg <= gate_next;
      base_reg <= base_next;
      irq_reg <= irq_next;
    end
  end

  assign crystal_clock_out = xtal_clk;
  assign base_clock_out = base_reg;
  assign clock_gen_irq = irq_reg;

endmodule : cgl_clock_gen

`default_nettype wire

/* tb/cgl_clock_gen_sva.sv */
// Checker of the clock generator outputs in wait and stop.
// Assumes it is bound to cgl_clock_gen and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module cgl_clock_gen_sva
  import cgl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register writes
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  // Mode strobes
  input wire logic wait_enter,
  input wire logic stop_enter,
  input wire logic mode_exit,
  // Outputs
  input wire logic crystal_clock_out,
  input wire logic base_clock_out,
  input wire logic clock_gen_irq
);
  logic stp, osc, wd;
  logic [7:0] wa;
  logic [3:0] sc;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Shadow of stop state and oscillator-in-stop bit; it lags the design,
  // so the stop checks on idle outputs only look at a settled stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {stp, osc, wd, wa, sc} <= '0;
    end else begin
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata[POS_OSC_RUN_STOP];
      if (bvalid && bready && wa == OFS_CONFIG) osc <= wd;
      if (stop_enter) stp <= 1'b1;
      else if (mode_exit) stp <= 1'b0;
      sc <= stop_enter ? 4'h0 : (stp && sc != 4'hF) ? sc + 4'h1 : sc;
    end
  end
  ////////////////////////////////////////
  sequence s_xtal_rise; ##[1:9] $rose(crystal_clock_out); endsequence
  sequence s_base_rise; ##[1:16] $rose(base_clock_out); endsequence
  property p_wait_xtal; wait_enter |-> s_xtal_rise; endproperty
  property p_wait_base; wait_enter |-> s_base_rise; endproperty
  property p_stop_xtal; stp && !osc && sc > 4'h9 |-> !crystal_clock_out; endproperty
  property p_stop_base; stp && sc > 4'h9 |-> !base_clock_out; endproperty
  property p_stop_irq; stp && !osc && sc > 4'h2 |-> !clock_gen_irq; endproperty
  property p_stop_osc; stp && osc |-> s_xtal_rise; endproperty
  property p_xtal_high; $rose(crystal_clock_out) |-> crystal_clock_out[*4]; endproperty
  property p_base_high; $rose(base_clock_out) |-> base_clock_out[*2]; endproperty
  a_wait_xtal: assert property (p_wait_xtal) else $error("crystal stalled in wait");
  a_wait_base: assert property (p_wait_base) else $error("base stalled in wait");
  a_stop_xtal: assert property (p_stop_xtal) else $error("crystal runs in stop");
  a_stop_base: assert property (p_stop_base) else $error("base runs in stop");
  a_stop_irq: assert property (p_stop_irq) else $error("irq high in stop");
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator halted");
  a_xtal_high: assert property (p_xtal_high) else $error("crystal runt pulse");
  a_base_high: assert property (p_base_high) else $error("base runt pulse");
endmodule : cgl_clock_gen_sva

bind cgl_clock_gen cgl_clock_gen_sva i_cgl_clock_gen_sva (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bvalid, .bready,
  .wait_enter, .stop_enter, .mode_exit, .crystal_clock_out, .base_clock_out, .clock_gen_irq
);
`default_nettype wire

/* tb/cgl_cpu_model.sv */
// CPU and system integration model: instruction strobes and break level.
// Assumes its tasks are called just after a rising aclk edge.
`timescale 1ns/10ps
`default_nettype none

module cgl_cpu_model (
  // Clock
  input wire logic aclk,
  // Strobes to the clock generator
  output var logic wait_enter,
  output var logic stop_enter,
  output var logic mode_exit,
  output var logic break_active
);
  initial {wait_enter, stop_enter, mode_exit, break_active} = '0;
  // One-cycle strobe after lag cycles: 0 wait, 1 stop, 2 exit
  task automatic strobe(input int k, input int lag);
    repeat (lag) @(posedge aclk);
    wait_enter <= (k == 0);
    stop_enter <= (k == 1);
    mode_exit <= (k == 2);
    @(posedge aclk);
    {wait_enter, stop_enter, mode_exit} <= '0;
  endtask : strobe
  task automatic brk(input logic v);
    break_active <= v;
  endtask : brk
endmodule : cgl_cpu_model
`default_nettype wire

/* tb/cgl_clock_gen_tb.sv */
// Self-checking bench of the clock generator low-power and break logic.
// Assumes the checker is bound to the design and the CPU model drives strobes.
`timescale 1ns/10ps
`default_nettype none

module cgl_clock_gen_tb
  import cgl_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lock_disturb;
  logic awready, wready, bvalid, arready, rvalid, xclk, bclk, irq;
  logic wait_enter, stop_enter, mode_exit, break_active;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int fails, num_checks, seed, n, nh, nr;

  cgl_clock_gen i_cgl_clock_gen (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .wait_enter, .stop_enter, .mode_exit, .break_active, .lock_disturb,
    .crystal_clock_out(xclk), .base_clock_out(bclk), .clock_gen_irq(irq));
  cgl_cpu_model i_cgl_cpu_model (.aclk, .wait_enter, .stop_enter, .mode_exit, .break_active);

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    {ad, dd} = 2'b00;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad | awready;
      dd = dd | wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    // Let one edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    // Same spacing on the read side, for back-to-back reads
    @(posedge aclk);
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    axr(a);
    chk(rd, e, m);
    chk({30'h0, rs}, {30'h0, RESP_OKAY}, m);
  endtask : rchk
  function automatic logic [31:0] st(input logic f, l, s, input logic [1:0] md);
    return {26'h0, md, 1'b0, s, l, f};
  endfunction : st
  task automatic wirq(input logic v, input string m);
    n = 0;
    while (irq !== v && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, v}, m);
  endtask : wirq
  // Counts busy output cycles and crystal rises over c cycles
  task automatic watch(input int c);
    logic p;
    p = xclk;
    {nh, nr} = '0;
    repeat (c) begin
      @(posedge aclk);
      if ({xclk, bclk, irq} !== 3'b000) nh++;
      if (xclk === 1'b1 && p === 1'b0) nr++;
      p = xclk;
    end
  endtask : watch
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    {seed, fails, num_checks} = {32'd76, 64'd0};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lock_disturb} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rchk(8'(4 * i), 32'h0, "reset value");
    axr(8'h14);
    chk(rd, 32'h0, "unmapped read data");
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    axw(8'h14, 32'hFFFF_FFFF);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
    repeat (6) begin
      rnd = $random(seed);
      n = 8 + 4 * (int'(rnd[9:8]) % 3);
      axw(8'(n), rnd);
      rchk(8'(n), {31'h0, rnd[0]}, "one-bit register");
    end
    // A write without byte lane 0 must leave the one-bit fields alone
    axw(OFS_IRQ_MASK, 32'h0);
    wstrb <= 4'hE;
    axw(OFS_IRQ_MASK, 32'h1);
    wstrb <= 4'hF;
    rchk(OFS_IRQ_MASK, 32'h0, "write without byte lane 0");
    done("registers");
    axw(OFS_IRQ_MASK, 32'h1);
    axw(OFS_CONFIG, 32'h0);
    axw(OFS_BREAK_CTRL, 32'h0);
    axw(OFS_LOOP_CTRL, 32'h5);
    i_cgl_cpu_model.strobe(0, int'(rnd[2:0]));
    wirq(1'b1, "lock irq in wait");
    rchk(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 2'h1), "locked in wait");
    i_cgl_cpu_model.strobe(2, 0);
    done("lock");
    i_cgl_cpu_model.brk(1'b1);
    axw(OFS_STATUS, 32'h1);
    rchk(OFS_LOOP_CTRL, 32'h5, "control in break");
    rchk(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 2'h0), "flag in break");
    i_cgl_cpu_model.brk(1'b0);
    rchk(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 2'h0), "flag after break");
    axw(OFS_BREAK_CTRL, 32'h1);
    i_cgl_cpu_model.brk(1'b1);
    axw(OFS_STATUS, 32'h1);
    rchk(OFS_STATUS, st(1'b0, 1'b1, 1'b0, 2'h0), "clear in break");
    i_cgl_cpu_model.brk(1'b0);
    wirq(1'b0, "irq after clear");
    rchk(OFS_STATUS, st(1'b0, 1'b1, 1'b0, 2'h0), "clear kept");
    done("break");
    lock_disturb <= 1'b1;
    wirq(1'b1, "lock loss irq");
    rchk(OFS_STATUS, st(1'b1, 1'b0, 1'b0, 2'h0), "lock lost");
    axw(OFS_STATUS, 32'h1);
    wirq(1'b0, "flag cleared");
    lock_disturb <= 1'b0;
    wirq(1'b1, "relock irq");
    done("lock loss");
    i_cgl_cpu_model.strobe(1, 0);
    repeat (12) @(posedge aclk);
    watch(16);
    chk(nh, 0, "outputs in stop");
    i_cgl_cpu_model.strobe(2, 0);
    watch(24);
    chk(32'(nr > 1), 32'h1, "crystal after stop");
    wirq(1'b1, "irq after stop");
    axw(OFS_CONFIG, 32'h1);
    i_cgl_cpu_model.strobe(1, int'(rnd[5:3]));
    watch(24);
    chk(32'(nr > 1), 32'h1, "crystal in stop");
    i_cgl_cpu_model.strobe(2, 0);
    done("stop");
    repeat (LOCK_ACQ_CYCLES + 20) @(posedge aclk);
    axw(OFS_LOOP_CTRL, 32'h7);
    repeat (12) @(posedge aclk);
    rchk(OFS_STATUS, st(1'b1, 1'b1, 1'b1, 2'h0), "loop selected");
    axw(OFS_LOOP_CTRL, 32'h5);
    // The source swap waits for both clocks low, up to a crystal period
    repeat (12) @(posedge aclk);
    i_cgl_cpu_model.strobe(0, 0);
    rchk(OFS_STATUS, st(1'b1, 1'b1, 1'b0, 2'h1), "loop kept in wait");
    i_cgl_cpu_model.strobe(2, 0);
    // Power saving sequence: deselect first, then power down
    axw(OFS_LOOP_CTRL, 32'h5);
    axw(OFS_LOOP_CTRL, 32'h4);
    i_cgl_cpu_model.strobe(0, 0);
    rchk(OFS_STATUS, st(1'b1, 1'b0, 1'b0, 2'h1), "loop off in wait");
    i_cgl_cpu_model.strobe(2, 0);
    // Manual bandwidth mode: no lock indicator and the flag reads zero
    axw(OFS_LOOP_CTRL, 32'h1);
    rchk(OFS_STATUS, 32'h0, "flag in manual mode");
    wirq(1'b0, "irq in manual mode");
    done("wait");
    wrap_up();
  end
endmodule : cgl_clock_gen_tb
`default_nettype wire
